/* hw/cdsc_defines.svh */
// Constants: offsets, field positions, reset values and opcode patterns
`ifndef CDSC_DEFINES_SVH
`define CDSC_DEFINES_SVH

////////////////////////////////////////////////////////////////////////
// Register map (byte offsets)
`define CDSC_OFF_STATUS_WORD 8'h00
`define CDSC_OFF_EVT_STATUS  8'h04
`define CDSC_OFF_EVT_MASK    8'h08
`define CDSC_OFF_LOOP_START  8'h0C
`define CDSC_OFF_LOOP_END    8'h10
`define CDSC_OFF_GPR_BASE    8'h40

////////////////////////////////////////////////////////////////////////
// Status word layout
`define CDSC_SW_T            0
`define CDSC_SW_RC_LO        16
`define CDSC_SW_RC_HI        27
`define CDSC_SW_WMASK        32'h0FFF0FFF
`define CDSC_SW_RESET        32'h00000000

////////////////////////////////////////////////////////////////////////
// Event bits
`define CDSC_EVT_W           5
`define CDSC_EVT_ADDR_RD     0
`define CDSC_EVT_ADDR_WR     1
`define CDSC_EVT_ILL_GEN     2
`define CDSC_EVT_ILL_SLOT    3
`define CDSC_EVT_ILL_LOOP    4

////////////////////////////////////////////////////////////////////////
// Access sizes
`define CDSC_SZ_BYTE         2'h0
`define CDSC_SZ_WORD         2'h1
`define CDSC_SZ_LONG         2'h2

////////////////////////////////////////////////////////////////////////
// Opcode patterns
`define CDSC_OP_ADD_RR       16'b0011_????_????_1100
`define CDSC_OP_ADD_IMM      16'b0111_????_????_????
`define CDSC_OP_NOP          16'h0009
`define CDSC_OP_BT           16'b1000_1001_????_????
`define CDSC_OP_BF           16'b1000_1011_????_????
`define CDSC_OP_BTS          16'b1000_1101_????_????
`define CDSC_OP_BFS          16'b1000_1111_????_????
`define CDSC_OP_BRA          16'b1010_????_????_????
`define CDSC_OP_BSR          16'b1011_????_????_????
`define CDSC_OP_BRAF         16'b0000_????_0010_0011
`define CDSC_OP_BSRF         16'b0000_????_0000_0011
`define CDSC_OP_JMP          16'b0100_????_0010_1011
`define CDSC_OP_JSR          16'b0100_????_0000_1011
`define CDSC_OP_RTS          16'h000B
`define CDSC_OP_RTE          16'h002B
`define CDSC_OP_TRAP         16'b1100_0011_????_????
`define CDSC_OP_LDC_SW       16'b0100_????_0000_1110
`define CDSC_OP_SETRC        16'b1000_0010_????_????
`define CDSC_OP_LDRS         16'b1000_1100_????_????
`define CDSC_OP_LDRE         16'b1000_1110_????_????

`endif

/* hw/cdsc_pkg.sv */
// Types shared by the decode and check logic
package cdsc_pkg;

  typedef enum logic [1:0] {
    CDSC_ST_RUN  = 2'h0,
    CDSC_ST_SLOT = 2'h1
  } cdsc_state_t;

  typedef enum logic [4:0] {
    CDSC_K_NONE, CDSC_K_NOP, CDSC_K_ADD_RR, CDSC_K_ADD_IMM,
    CDSC_K_BT, CDSC_K_BF, CDSC_K_BTS, CDSC_K_BFS, CDSC_K_BRA,
    CDSC_K_BSR, CDSC_K_BRAF, CDSC_K_BSRF, CDSC_K_JMP, CDSC_K_JSR,
    CDSC_K_RTS, CDSC_K_RTE, CDSC_K_TRAP, CDSC_K_LDC_SW,
    CDSC_K_SETRC, CDSC_K_LDRS, CDSC_K_LDRE
  } cdsc_kind_t;

  typedef enum logic [2:0] {
    CDSC_C_NONE = 3'h0,
    CDSC_C_ADDR = 3'h1,
    CDSC_C_GEN  = 3'h2,
    CDSC_C_SLOT = 3'h3,
    CDSC_C_LOOP = 3'h4
  } cdsc_cause_t;

  typedef struct packed {
    cdsc_state_t        state;
    logic [15:0][31:0]  gpr;
    logic [31:0]        ret_addr;
    logic [31:0]        status_word;
    logic [31:0]        loop_start_addr;
    logic [31:0]        loop_end_addr;
    logic [4:0]         evt;
    logic [4:0]         mask;
    logic [31:0]        target;
    logic               take;
    logic [31:0]        rd_data;
    logic               irq;
    logic               addr_err;
    logic               illegal;
    cdsc_cause_t        cause;
    logic               redirect;
    logic [31:0]        redirect_pc;
    logic               sys_op;
  } cdsc_core_t;

endpackage

/* hw/cdsc_align_chk.sv */
// Alignment check for one data access port
`timescale 1ns/100ps
`include "cdsc_defines.svh"

module cdsc_align_chk (
  // Access
  input  wire logic        valid,
  input  wire logic [1:0]  size,
  input  wire logic [1:0]  addr_lo,
  // Result
  output logic             misaligned
);

  always_comb begin
    misaligned = 1'b0;
    if (valid) begin
      if (size == `CDSC_SZ_WORD)
        misaligned = addr_lo[0];
      else if (size == `CDSC_SZ_LONG)
        misaligned = |addr_lo;
    end
  end

endmodule

/* hw/cdsc_opclass.sv */
// Opcode classifier for the decode slice
`timescale 1ns/100ps
`include "cdsc_defines.svh"

module cdsc_opclass (
  // Opcode
  input  wire logic [15:0]        code,
  // Class
  output cdsc_pkg::cdsc_kind_t    kind,
  output logic                    br_class,
  output logic                    ctl_write
);

  always_comb begin
    casez (code)
      `CDSC_OP_NOP:     kind = cdsc_pkg::CDSC_K_NOP;
      `CDSC_OP_RTS:     kind = cdsc_pkg::CDSC_K_RTS;
      `CDSC_OP_RTE:     kind = cdsc_pkg::CDSC_K_RTE;
      `CDSC_OP_ADD_RR:  kind = cdsc_pkg::CDSC_K_ADD_RR;
      `CDSC_OP_ADD_IMM: kind = cdsc_pkg::CDSC_K_ADD_IMM;
      `CDSC_OP_BT:      kind = cdsc_pkg::CDSC_K_BT;
      `CDSC_OP_BF:      kind = cdsc_pkg::CDSC_K_BF;
      `CDSC_OP_BTS:     kind = cdsc_pkg::CDSC_K_BTS;
      `CDSC_OP_BFS:     kind = cdsc_pkg::CDSC_K_BFS;
      `CDSC_OP_BRA:     kind = cdsc_pkg::CDSC_K_BRA;
      `CDSC_OP_BSR:     kind = cdsc_pkg::CDSC_K_BSR;
      `CDSC_OP_BRAF:    kind = cdsc_pkg::CDSC_K_BRAF;
      `CDSC_OP_BSRF:    kind = cdsc_pkg::CDSC_K_BSRF;
      `CDSC_OP_JMP:     kind = cdsc_pkg::CDSC_K_JMP;
      `CDSC_OP_JSR:     kind = cdsc_pkg::CDSC_K_JSR;
      `CDSC_OP_TRAP:    kind = cdsc_pkg::CDSC_K_TRAP;
      `CDSC_OP_LDC_SW:  kind = cdsc_pkg::CDSC_K_LDC_SW;
      `CDSC_OP_SETRC:   kind = cdsc_pkg::CDSC_K_SETRC;
      `CDSC_OP_LDRS:    kind = cdsc_pkg::CDSC_K_LDRS;
      `CDSC_OP_LDRE:    kind = cdsc_pkg::CDSC_K_LDRE;
      default:          kind = cdsc_pkg::CDSC_K_NONE;
    endcase
  end

  // Every decoded opcode that may not sit in a delay slot
  always_comb begin
    case (kind)
      cdsc_pkg::CDSC_K_BT, cdsc_pkg::CDSC_K_BF, cdsc_pkg::CDSC_K_BTS,
      cdsc_pkg::CDSC_K_BFS, cdsc_pkg::CDSC_K_BRA, cdsc_pkg::CDSC_K_BSR,
      cdsc_pkg::CDSC_K_BRAF, cdsc_pkg::CDSC_K_BSRF, cdsc_pkg::CDSC_K_JMP,
      cdsc_pkg::CDSC_K_JSR, cdsc_pkg::CDSC_K_RTS, cdsc_pkg::CDSC_K_RTE,
      cdsc_pkg::CDSC_K_TRAP: br_class = 1'b1;
      default:               br_class = 1'b0;
    endcase
  end

  always_comb begin
    case (kind)
      cdsc_pkg::CDSC_K_LDC_SW, cdsc_pkg::CDSC_K_SETRC,
      cdsc_pkg::CDSC_K_LDRS, cdsc_pkg::CDSC_K_LDRE: ctl_write = 1'b1;
      default:                                      ctl_write = 1'b0;
    endcase
  end

endmodule

/* hw/cdsc_core.sv */
// Decode, slot and loop checks, add datapath and status registers
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/100ps
`include "cdsc_defines.svh"

module cdsc_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Instruction issue
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_code,
  input  wire logic [31:0] instr_addr,
  input  wire logic        other_hit,
  // Data access check
  input  wire logic        rd_valid,
  input  wire logic [1:0]  rd_size,
  input  wire logic [31:0] rd_addr,
  input  wire logic        wr_valid,
  input  wire logic [1:0]  wr_size,
  input  wire logic [31:0] wr_addr,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Exceptions and flow
  output logic             addr_error,
  output logic             illegal_exc,
  output logic [2:0]       exc_cause,
  output logic             redirect_valid,
  output logic [31:0]      redirect_pc,
  output logic             sys_op,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  cdsc_pkg::cdsc_core_t  cur_reg;
  cdsc_pkg::cdsc_core_t  cur_next;
  cdsc_pkg::cdsc_kind_t  kind;
  logic                  br_class;
  logic                  ctl_write;
  logic                  rd_mis;
  logic                  wr_mis;

  cdsc_opclass u_opclass (
    .code      (instr_code),
    .kind      (kind),
    .br_class  (br_class),
    .ctl_write (ctl_write)
  );

  cdsc_align_chk u_rd_chk (
    .valid      (rd_valid),
    .size       (rd_size),
    .addr_lo    (rd_addr[1:0]),
    .misaligned (rd_mis)
  );

  cdsc_align_chk u_wr_chk (
    .valid      (wr_valid),
    .size       (wr_size),
    .addr_lo    (wr_addr[1:0]),
    .misaligned (wr_mis)
  );

  ////////////////////////////////////////////////////////////////////
  // Decode fields

  logic [3:0]  fld_n;
  logic [3:0]  fld_m;
  logic [31:0] pc_plus4;
  logic [31:0] disp8;
  logic [31:0] disp12;
  logic [31:0] imm8;
  logic [11:0] loop_count;
  logic        in_tail;
  logic        unassigned;
  logic        in_slot;
  logic        slot_bad;
  logic        loop_bad;
  logic        t_flag;

  assign fld_n      = instr_code[11:8];
  assign fld_m      = instr_code[7:4];
  assign pc_plus4   = instr_addr + 32'h00000004;
  assign disp8      = {{23{instr_code[7]}}, instr_code[7:0], 1'b0};
  assign disp12     = {{19{instr_code[11]}}, instr_code[11:0], 1'b0};
  assign imm8       = {{24{instr_code[7]}}, instr_code[7:0]};
  assign t_flag     = cur_reg.status_word[`CDSC_SW_T];
  assign loop_count =
    cur_reg.status_word[`CDSC_SW_RC_HI:`CDSC_SW_RC_LO];

  // Last three halfword positions of an active loop
  assign in_tail = (loop_count != 12'h000) &&
    (instr_addr == cur_reg.loop_end_addr ||
     instr_addr == cur_reg.loop_end_addr - 32'h00000002 ||
     instr_addr == cur_reg.loop_end_addr - 32'h00000004);

  assign unassigned = (kind == cdsc_pkg::CDSC_K_NONE) && !other_hit;
  assign in_slot    = (cur_reg.state == cdsc_pkg::CDSC_ST_SLOT);
  assign slot_bad   = in_slot && (unassigned || br_class);
  assign loop_bad   = in_tail &&
                      (unassigned || br_class || ctl_write);

  ////////////////////////////////////////////////////////////////////
  // Next state

  logic [4:0]  evt_set;
  logic [4:0]  evt_clr;
  logic [3:0]  gpr_idx;

  always_comb begin
    cur_next          = cur_reg;
    evt_set           = 5'h00;
    evt_clr           = 5'h00;
    gpr_idx           = reg_addr[5:2];
    cur_next.addr_err = 1'b0;
    cur_next.illegal  = 1'b0;
    cur_next.redirect = 1'b0;
    cur_next.sys_op   = 1'b0;
    cur_next.rd_data  = 32'h00000000;

    // Data access alignment
    if (rd_mis) begin
      evt_set[`CDSC_EVT_ADDR_RD] = 1'b1;
    end
    if (wr_mis) begin
      evt_set[`CDSC_EVT_ADDR_WR] = 1'b1;
    end
    if (rd_mis || wr_mis) begin
      cur_next.addr_err = 1'b1;
      cur_next.cause    = cdsc_pkg::CDSC_C_ADDR;
    end

    if (instr_valid) begin
      if (slot_bad) begin
        // Slot instruction is dropped and the pending branch abandoned
        cur_next.illegal = 1'b1;
        cur_next.cause   = cdsc_pkg::CDSC_C_SLOT;
        cur_next.state   = cdsc_pkg::CDSC_ST_RUN;
        cur_next.take    = 1'b0;
        evt_set[`CDSC_EVT_ILL_SLOT] = 1'b1;
      end else if (loop_bad) begin
        cur_next.illegal = 1'b1;
        cur_next.cause   = cdsc_pkg::CDSC_C_LOOP;
        // A trapped slot instruction also drops the pending jump
        cur_next.state   = cdsc_pkg::CDSC_ST_RUN;
        cur_next.take    = 1'b0;
        evt_set[`CDSC_EVT_ILL_LOOP] = 1'b1;
      end else if (unassigned) begin
        cur_next.illegal = 1'b1;
        cur_next.cause   = cdsc_pkg::CDSC_C_GEN;
        evt_set[`CDSC_EVT_ILL_GEN] = 1'b1;
      end else begin
        case (kind)
          cdsc_pkg::CDSC_K_ADD_RR: begin
            cur_next.gpr[fld_n] =
              cur_reg.gpr[fld_n] + cur_reg.gpr[fld_m];
          end

          cdsc_pkg::CDSC_K_ADD_IMM: begin
            cur_next.gpr[fld_n] = cur_reg.gpr[fld_n] + imm8;
          end

          cdsc_pkg::CDSC_K_BT, cdsc_pkg::CDSC_K_BF: begin
            if (t_flag == (kind == cdsc_pkg::CDSC_K_BT)) begin
              cur_next.redirect    = 1'b1;
              cur_next.redirect_pc = pc_plus4 + disp8;
            end
          end

          cdsc_pkg::CDSC_K_BTS, cdsc_pkg::CDSC_K_BFS: begin
            cur_next.state  = cdsc_pkg::CDSC_ST_SLOT;
            cur_next.take   = (t_flag == (kind == cdsc_pkg::CDSC_K_BTS));
            cur_next.target = pc_plus4 + disp8;
          end

          cdsc_pkg::CDSC_K_BRA, cdsc_pkg::CDSC_K_BSR: begin
            cur_next.state  = cdsc_pkg::CDSC_ST_SLOT;
            cur_next.take   = 1'b1;
            cur_next.target = pc_plus4 + disp12;
            if (kind == cdsc_pkg::CDSC_K_BSR)
              cur_next.ret_addr = pc_plus4;
          end

          cdsc_pkg::CDSC_K_BRAF, cdsc_pkg::CDSC_K_BSRF: begin
            // Target frozen now so the slot cannot move it
            cur_next.state  = cdsc_pkg::CDSC_ST_SLOT;
            cur_next.take   = 1'b1;
            cur_next.target = pc_plus4 + cur_reg.gpr[fld_n];
            if (kind == cdsc_pkg::CDSC_K_BSRF)
              cur_next.ret_addr = pc_plus4;
          end

          cdsc_pkg::CDSC_K_JMP, cdsc_pkg::CDSC_K_JSR: begin
            cur_next.state  = cdsc_pkg::CDSC_ST_SLOT;
            cur_next.take   = 1'b1;
            cur_next.target = cur_reg.gpr[fld_n];
            if (kind == cdsc_pkg::CDSC_K_JSR)
              cur_next.ret_addr = pc_plus4;
          end

          cdsc_pkg::CDSC_K_RTS: begin
            cur_next.state  = cdsc_pkg::CDSC_ST_SLOT;
            cur_next.take   = 1'b1;
            cur_next.target = cur_reg.ret_addr;
          end

          cdsc_pkg::CDSC_K_RTE: begin
            // Return target is restored outside; slot still checked
            cur_next.state  = cdsc_pkg::CDSC_ST_SLOT;
            cur_next.take   = 1'b0;
            cur_next.sys_op = 1'b1;
          end

          cdsc_pkg::CDSC_K_TRAP: begin
            cur_next.sys_op = 1'b1;
          end

          cdsc_pkg::CDSC_K_LDC_SW: begin
            cur_next.status_word =
              cur_reg.gpr[fld_n] & `CDSC_SW_WMASK;
          end

          cdsc_pkg::CDSC_K_SETRC: begin
            cur_next.status_word[`CDSC_SW_RC_HI:`CDSC_SW_RC_LO] =
              {4'h0, instr_code[7:0]};
          end

          cdsc_pkg::CDSC_K_LDRS: begin
            cur_next.loop_start_addr = pc_plus4 + disp8;
          end

          cdsc_pkg::CDSC_K_LDRE: begin
            cur_next.loop_end_addr = pc_plus4 + disp8;
          end
          default: begin
          end
        endcase

        // Slot done: now hand over to the captured target
        if (in_slot) begin
          cur_next.state       = cdsc_pkg::CDSC_ST_RUN;
          cur_next.redirect    = cur_reg.take;
          cur_next.redirect_pc = cur_reg.target;
          cur_next.take        = 1'b0;
        end
      end
    end

    // Register port writes win over instruction updates, except that event sets beat event clears
    if (reg_wr) begin
      case (reg_addr)
        `CDSC_OFF_STATUS_WORD:
          cur_next.status_word = reg_wdata & `CDSC_SW_WMASK;

        `CDSC_OFF_EVT_STATUS:
          evt_clr = reg_wdata[4:0];

        `CDSC_OFF_EVT_MASK:
          cur_next.mask = reg_wdata[4:0];

        `CDSC_OFF_LOOP_START:
          cur_next.loop_start_addr = reg_wdata;

        `CDSC_OFF_LOOP_END:
          cur_next.loop_end_addr = reg_wdata;
        default: begin
        end
      endcase
    end

    // Set beats clear in the same cycle
    cur_next.evt = (cur_reg.evt & ~evt_clr) | evt_set;
    cur_next.irq = |(cur_next.evt & cur_next.mask);

    if (reg_rd) begin
      case (reg_addr)
        `CDSC_OFF_STATUS_WORD:
          cur_next.rd_data = cur_reg.status_word;

        `CDSC_OFF_EVT_STATUS:
          cur_next.rd_data = {27'h0, cur_reg.evt};

        `CDSC_OFF_EVT_MASK:
          cur_next.rd_data = {27'h0, cur_reg.mask};

        `CDSC_OFF_LOOP_START:
          cur_next.rd_data = cur_reg.loop_start_addr;

        `CDSC_OFF_LOOP_END:
          cur_next.rd_data = cur_reg.loop_end_addr;
        default: begin
          if (reg_addr[7:6] == `CDSC_OFF_GPR_BASE >> 6)
            cur_next.rd_data = cur_reg.gpr[gpr_idx];
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_reg.state           <= cdsc_pkg::CDSC_ST_RUN;
      cur_reg.gpr             <= '0;
      cur_reg.ret_addr        <= 32'h00000000;
      cur_reg.status_word     <= `CDSC_SW_RESET;
      cur_reg.loop_start_addr <= 32'h00000000;
      cur_reg.loop_end_addr   <= 32'h00000000;
      cur_reg.evt             <= 5'h00;
      cur_reg.mask            <= 5'h00;
      cur_reg.target          <= 32'h00000000;
      cur_reg.take            <= 1'b0;
      cur_reg.rd_data         <= 32'h00000000;
      cur_reg.irq             <= 1'b0;
      cur_reg.addr_err        <= 1'b0;
      cur_reg.illegal         <= 1'b0;
      cur_reg.cause           <= cdsc_pkg::CDSC_C_NONE;
      cur_reg.redirect        <= 1'b0;
      cur_reg.redirect_pc     <= 32'h00000000;
      cur_reg.sys_op          <= 1'b0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata      = cur_reg.rd_data;
  assign addr_error     = cur_reg.addr_err;
  assign illegal_exc    = cur_reg.illegal;
  assign exc_cause      = cur_reg.cause;
  assign redirect_valid = cur_reg.redirect;
  assign redirect_pc    = cur_reg.redirect_pc;
  assign sys_op         = cur_reg.sys_op;
  assign irq            = cur_reg.irq;

endmodule

/* test/cdsc_core_props.sv */
// Concurrent checks on the ports of the decode and exception block
`timescale 1ns/100ps
`include "cdsc_defines.svh"

module cdsc_core_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Instruction issue
  input wire logic        instr_valid,
  input wire logic [15:0] instr_code,
  input wire logic [31:0] instr_addr,
  input wire logic        other_hit,
  // Data access check
  input wire logic        rd_valid,
  input wire logic [1:0]  rd_size,
  input wire logic [31:0] rd_addr,
  input wire logic        wr_valid,
  input wire logic [1:0]  wr_size,
  input wire logic [31:0] wr_addr,
  // Exceptions and flow
  input wire logic        addr_error,
  input wire logic        illegal_exc,
  input wire logic [2:0]  exc_cause,
  input wire logic        redirect_valid,
  input wire logic [31:0] redirect_pc,
  input wire logic        sys_op
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic        slot_reg;
  logic        slot_eff;
  logic        bra_q;
  logic [31:0] tgt_reg;
  logic        rd_mis;
  logic        wr_mis;
  logic        is_bra;

  assign is_bra = instr_valid && instr_code[15:12] == 4'hA;
  assign rd_mis = rd_valid && ((rd_size == `CDSC_SZ_WORD && rd_addr[0])
                  || (rd_size == `CDSC_SZ_LONG && rd_addr[1:0] != 2'h0));
  assign wr_mis = wr_valid && ((wr_size == `CDSC_SZ_WORD && wr_addr[0])
                  || (wr_size == `CDSC_SZ_LONG && wr_addr[1:0] != 2'h0));

  // Tracks the slot after an unconditional delayed jump and its target
  // A jump that was itself trapped opens no slot
  assign slot_eff = slot_reg && !(bra_q && illegal_exc);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_reg <= 1'b0;
      bra_q    <= 1'b0;
      tgt_reg  <= 32'h0;
    end else begin
      bra_q <= is_bra && !slot_eff;
      if (!instr_valid) begin
        slot_reg <= slot_eff;
      end else begin
        slot_reg <= is_bra && !slot_eff;
        if (is_bra && !slot_eff) begin
          tgt_reg <= instr_addr + 32'h4
                     + {{19{instr_code[11]}}, instr_code[11:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_rd_misalign: assert property (rd_mis |=> addr_error && exc_cause == 3'h1)
    else $error("misaligned read without address error");
  a_wr_misalign: assert property (wr_mis |=> addr_error && exc_cause == 3'h1)
    else $error("misaligned write without address error");
  a_addr_quiet: assert property (!rd_mis && !wr_mis |=> !addr_error)
    else $error("address error without misaligned access");
  a_unassigned_trap: assert property (instr_valid && instr_code == 16'hFFFF
    && !other_hit |=> illegal_exc)
    else $error("unassigned opcode not trapped");
  a_slot_illegal: assert property (instr_valid && slot_eff
    && instr_code == 16'hFFFF
    |=> illegal_exc && exc_cause == 3'h3 && !redirect_valid)
    else $error("illegal slot opcode not trapped");
  a_slot_branch: assert property (instr_valid && slot_eff
    && (instr_code[15:13] == 3'b101 || instr_code == 16'h000B
    || instr_code == 16'h002B) |=> illegal_exc && exc_cause == 3'h3 && !sys_op)
    else $error("branch in slot not trapped");
  a_slot_first: assert property (is_bra && !slot_eff |=> !redirect_valid)
    else $error("jump taken before its slot");
  a_jump_after_slot: assert property (instr_valid && slot_eff
    && instr_code == 16'h0009
    |=> redirect_valid && redirect_pc == tgt_reg && !illegal_exc)
    else $error("jump after slot missing or wrong target");
endmodule

bind cdsc_core cdsc_core_props u_props (
  .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_code(instr_code),
  .instr_addr(instr_addr), .other_hit(other_hit), .rd_valid(rd_valid),
  .rd_size(rd_size), .rd_addr(rd_addr), .wr_valid(wr_valid),
  .wr_size(wr_size), .wr_addr(wr_addr), .addr_error(addr_error),
  .illegal_exc(illegal_exc), .exc_cause(exc_cause),
  .redirect_valid(redirect_valid), .redirect_pc(redirect_pc), .sys_op(sys_op)
);

/* test/cdsc_core_tb_top.sv */
// Self-checking testbench for the decode and exception check block
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
  mismatches++; $display("mismatch %s expected %h seen %h", nm, exp, got); \
  end end

module cdsc_core_tb_top;
  logic        clk, rst, instr_valid, other_hit, rd_valid, wr_valid;
  logic        reg_wr, reg_rd, addr_error, illegal_exc, redirect_valid;
  logic        sys_op, irq;
  logic [15:0] instr_code;
  logic [31:0] instr_addr, rd_addr, wr_addr, reg_wdata, reg_rdata;
  logic [31:0] redirect_pc;
  logic [1:0]  rd_size, wr_size;
  logic [7:0]  reg_addr;
  logic [2:0]  exc_cause;
  int          mismatches = 0;
  int          checks_done = 0;

  cdsc_core uut (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr_code(instr_code), .instr_addr(instr_addr), .other_hit(other_hit),
    .rd_valid(rd_valid), .rd_size(rd_size), .rd_addr(rd_addr),
    .wr_valid(wr_valid), .wr_size(wr_size), .wr_addr(wr_addr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_error(addr_error),
    .illegal_exc(illegal_exc), .exc_cause(exc_cause),
    .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
    .sys_op(sys_op), .irq(irq));

  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_t(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic issue(input logic [15:0] c, input logic [31:0] a,
                       input logic oh);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_code  <= c;
    instr_addr  <= a;
    other_hit   <= oh;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic acc(input logic w, input logic [1:0] s, input logic [31:0] a);
    @(posedge clk);
    rd_valid <= !w;
    wr_valid <= w;
    rd_size  <= s;
    wr_size  <= s;
    rd_addr  <= a;
    wr_addr  <= a;
    @(posedge clk);
    rd_valid <= 1'b0;
    wr_valid <= 1'b0;
    #1;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      rd_t(8'(4 * i), d);
      `CHK("reset value", 32'h0, d)
    end
    wr_t(8'h00, 32'hFFFFFFFF);
    rd_t(8'h00, d);
    `CHK("status layout", 32'h0FFF0FFF, d)
    rd_t(8'h24, d);
    `CHK("unmapped read", 32'h0, d)
    wr_t(8'h00, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_align;
    logic [1:0]  sz [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [31:0] lo [6] = '{32'h3, 32'h1, 32'h2, 32'h2, 32'h1, 32'h4};
    logic        ex [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] d;
    logic        w;
    wr_t(8'h08, 32'h1);
    for (int i = 0; i < 12; i++) begin
      w = (i >= 6);
      acc(w, sz[i % 6], 32'h1000 + lo[i % 6]);
      `CHK("addr_error", ex[i % 6], addr_error)
      if (ex[i % 6]) begin
        `CHK("cause", 3'h1, exc_cause)
        rd_t(8'h04, d);
        `CHK("event bit", 32'h1 << w, d)
        `CHK("irq masked", !w, irq)
        wr_t(8'h04, d);
        rd_t(8'h04, d);
        `CHK("event clear", 32'h0, d)
        `CHK("irq clear", 1'b0, irq)
      end
    end
    $display("test align done");
  endtask

  task automatic t_add;
    logic [31:0] d;
    wr_t(8'h00, 32'h1);
    issue(16'h7201, 32'h0, 1'b0);
    issue(16'h73FE, 32'h2, 1'b0);
    rd_t(8'h4C, d);
    `CHK("negative imm", 32'hFFFFFFFE, d)
    issue(16'h323C, 32'h4, 1'b0);
    rd_t(8'h48, d);
    `CHK("reg sum", 32'hFFFFFFFF, d)
    rd_t(8'h00, d);
    `CHK("flag kept", 32'h1, d)
    issue(16'h8902, 32'h10, 1'b0);
    `CHK("branch", 1'b1, redirect_valid)
    `CHK("branch pc", 32'h18, redirect_pc)
    wr_t(8'h00, 32'h0);
    $display("test add done");
  endtask

  task automatic t_unassigned;
    issue(16'hFFFF, 32'h300, 1'b0);
    `CHK("illegal", 1'b1, illegal_exc)
    `CHK("cause", 3'h2, exc_cause)
    issue(16'hFFFF, 32'h300, 1'b1);
    `CHK("owned elsewhere", 1'b0, illegal_exc)
    issue(16'hC300, 32'h300, 1'b0);
    `CHK("trap", 1'b1, sys_op)
    $display("test unassigned done");
  endtask

  task automatic t_slot;
    logic [15:0] br [13] = '{16'h8900, 16'h8B00, 16'hA000, 16'hB000,
      16'h402B, 16'h400B, 16'h000B, 16'h002B, 16'hC300, 16'h8D00,
      16'h8F00, 16'h0023, 16'h0003};
    issue(16'hA010, 32'h100, 1'b0);
    `CHK("early jump", 1'b0, redirect_valid)
    issue(16'h0009, 32'h102, 1'b0);
    `CHK("jump", 1'b1, redirect_valid)
    `CHK("target", 32'h124, redirect_pc)
    issue(16'hA010, 32'h100, 1'b0);
    issue(16'hFFFF, 32'h102, 1'b0);
    `CHK("slot illegal", 1'b1, illegal_exc)
    `CHK("slot cause", 3'h3, exc_cause)
    `CHK("no jump", 1'b0, redirect_valid)
    for (int i = 0; i < 13; i++) begin
      issue(16'hA010, 32'h100, 1'b0);
      issue(br[i], 32'h102, 1'b0);
      `CHK("branch in slot", 1'b1, illegal_exc)
      `CHK("branch cause", 3'h3, exc_cause)
    end
    $display("test slot done");
  endtask

  task automatic t_target;
    logic [31:0] d;
    issue(16'h7404, 32'h0, 1'b0);
    issue(16'h442B, 32'h200, 1'b0);
    issue(16'h7408, 32'h202, 1'b0);
    `CHK("reg jump", 1'b1, redirect_valid)
    `CHK("old target", 32'h4, redirect_pc)
    rd_t(8'h50, d);
    `CHK("slot ran", 32'hC, d)
    $display("test target done");
  endtask

  task automatic t_loop;
    logic [15:0] tl [5] = '{16'h8201, 16'hA010, 16'hFFFF, 16'h410E, 16'h8C00};
    wr_t(8'h10, 32'h200);
    wr_t(8'h00, 32'h00010000);
    issue(16'h8E01, 32'h1FA, 1'b0);
    `CHK("before tail", 1'b0, illegal_exc)
    for (int i = 0; i < 5; i++) begin
      issue(tl[i], 32'h1FC + 32'(2 * (i % 3)), 1'b0);
      `CHK("tail illegal", 1'b1, illegal_exc)
      `CHK("tail cause", 3'h4, exc_cause)
    end
    wr_t(8'h00, 32'h0);
    $display("test loop done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, instr_valid, other_hit, rd_valid, wr_valid, reg_wr, reg_rd} = '0;
    rst = 1'b1;
    {instr_code, instr_addr, rd_addr, wr_addr, reg_wdata} = '0;
    {rd_size, wr_size, reg_addr} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_align;
    t_add;
    t_unassigned;
    t_slot;
    t_target;
    t_loop;
    complete_run;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #800000;
    mismatches++;
    complete_run;
  end
endmodule
